// ---- logic/deafc_defines.vh ----
/*
 * constants for the debug entry and freeze control block: state codes,
 * field encodings and default sizes.
 * assumes it is included by bare name from the design files only.
 */
`ifndef DEAFC_DEFINES_VH
`define DEAFC_DEFINES_VH

// debug supervision states
`define DEAFC_ST_NORMAL     2'h0
`define DEAFC_ST_DEBUG      2'h1
`define DEAFC_ST_ROGUE      2'h2

// queued converter debug stop field: this code keeps it converting
`define DEAFC_QC_RUN_CODE   2'h0
`define DEAFC_QC_FLD_W      2

// pin sampling lanes in the synchroniser
`define DEAFC_PIN_COMP      0
`define DEAFC_PIN_DBG       1
`define DEAFC_PIN_TEST      2
`define DEAFC_PIN_CMD       3
`define DEAFC_PIN_W         4

// default instance counts
`define DEAFC_TIO_CH_DEF    8
`define DEAFC_IGF_DEF       4
`define DEAFC_SNS_CH_DEF    2

`endif

// ---- logic/deafc_freeze.v ----
/*
 * per-lane halt decision: a lane halts while debug mode is active and
 * its own freeze control is set.
 * assumes all inputs are on clk_i; halts are registered.
 */
`timescale 1ns/10ps
module deafc_freeze
#(
    parameter W = 8
)
(
    input  wire         clk_i,
    input  wire         srst_i,
    input  wire         dbg_active_i,
    input  wire [W-1:0] freeze_en_i,
    output wire [W-1:0] halt_o
);
    reg [W-1:0] halt_r;

    genvar g;
    generate
        for (g = 0; g < W; g = g + 1)
        begin : lane
            always @(posedge clk_i)
            begin
                if (srst_i)
                    halt_r[g] <= 1'b0;
                else
                    halt_r[g] <= dbg_active_i & freeze_en_i[g];
            end
        end
    endgenerate

    assign halt_o = halt_r;
endmodule

// ---- logic/deafc_sync.v ----
/*
 * two flip-flop synchroniser for a group of independent pin levels.
 * assumes each lane is a slow level; multi-bit words are not coherent.
 */
`timescale 1ns/10ps
module deafc_sync
#(
    parameter W = 4
)
(
    input  wire         clk_i,
    input  wire         srst_i,
    input  wire [W-1:0] d_i,
    output wire [W-1:0] q_o
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    // first stage is read by the second stage only
    always @(posedge clk_i)
    begin
        if (srst_i)
        begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end
        else
        begin
            meta_r <= d_i;
            sync_r <= meta_r;
        end
    end

    assign q_o = sync_r;
endmodule

// ---- logic/deafc_top.v ----
/*
 * debug entry supervision and peripheral freeze distribution.
 * assumes pins (compliance select, debug request, test, command strobe)
 * are asynchronous; all other inputs are on CLK_I.
 */
// How it works
// - compliance select low holds tap in reset
// - compliance select high releases tap for debug
// - debug entry with select low reports fault
// - after fault recognition, tap commands are refused
// - watchdog keeps counting when freeze bit clear
// - sigma delta converter runs when freeze clear
// - queued converter runs when stop field zero
// - decimation filter unfrozen when request enable clear
// - system timer runs when freeze bit clear
// - periodic timer runs when freeze bit clear
// - timer io runs unless global and channel freeze
// - reaction module unfrozen when request enable clear
// - each glitch filter unfrozen when freeze clear
// - can controller keeps communicating when freeze clear
// - serial port completes active transfer when freeze clear
// - interprocessor link keeps transferring when freeze clear
// - interrupt controller unaffected by debug mode
// - sensor channel runs when debug enable clear
// - dma engine runs when stall enable clear
// - fault unit runs when debug control clear
// - test mode entry supervised and reported
`timescale 1ns/10ps
`include "deafc_defines.vh"
module deafc_top
#(
    parameter TIO_CH = `DEAFC_TIO_CH_DEF,
    parameter IGF_N  = `DEAFC_IGF_DEF,
    parameter SNS_CH = `DEAFC_SNS_CH_DEF
)
(
    input  wire                     CLK_I,
    input  wire                     SRST_I,
    // pins
    input  wire                     TAP_COMPLIANCE_SELECT_I,
    input  wire                     DEBUG_REQ_I,
    input  wire                     TEST_PIN_I,
    input  wire                     TAP_CMD_STROBE_I,
    // fault collection unit side
    input  wire                     FCU_DBG_FAULT_ACK_I,
    input  wire                     FCU_TEST_SUPERVISE_EN_I,
    input  wire                     FAULT_STS_CLR_I,
    // freeze controls
    input  wire                     WDOG_FREEZE_I,
    input  wire                     SDC_FREEZE_I,
    input  wire [`DEAFC_QC_FLD_W-1:0] QC_DEBUG_STOP_I,
    input  wire                     DECF_FREEZE_REQ_EN_I,
    input  wire                     STM_FREEZE_I,
    input  wire                     PIT_FREEZE_I,
    input  wire                     TIO_FREEZE_I,
    input  wire [TIO_CH-1:0]        TIO_CH_FREEZE_MASK_I,
    input  wire                     REAC_FREEZE_REQ_EN_I,
    input  wire [IGF_N-1:0]         IGF_FREEZE_I,
    input  wire                     CAN_FREEZE_I,
    input  wire                     SPP_FREEZE_I,
    input  wire                     SPP_XFER_BUSY_I,
    input  wire                     ISL_FREEZE_I,
    input  wire [SNS_CH-1:0]        SNS_DEBUG_EN_I,
    input  wire                     DMA_STALL_EN_I,
    input  wire                     FCU_DEBUG_CTRL_I,
    // tap and supervision outputs
    output wire                     TAP_RESET_O,
    output wire                     TAP_CMD_ACCEPT_O,
    output wire                     TAP_LOCKOUT_O,
    output wire                     DEBUG_ACTIVE_O,
    output wire                     FCU_DBG_FAULT_O,
    output wire                     FCU_TEST_FAULT_O,
    output wire                     DBG_FAULT_STS_O,
    output wire                     TEST_FAULT_STS_O,
    output wire                     TEST_MODE_O,
    // halts
    output wire                     WDOG_HALT_O,
    output wire                     SDC_HALT_O,
    output wire                     QC_HALT_O,
    output wire                     DECF_HALT_O,
    output wire                     STM_HALT_O,
    output wire                     PIT_HALT_O,
    output wire [TIO_CH-1:0]        TIO_CH_HALT_O,
    output wire                     REAC_HALT_O,
    output wire [IGF_N-1:0]         IGF_HALT_O,
    output wire                     CAN_HALT_O,
    output wire                     SPP_HALT_O,
    output wire                     ISL_HALT_O,
    output wire                     INTERRUPT_CONTROLLER_HALT_O,
    output wire [SNS_CH-1:0]        SNS_HALT_O,
    output wire                     DMA_HALT_O,
    output wire                     FCU_HALT_O
);
    // freeze lane layout, lsb first
    localparam L_WDOG = 0;
    localparam L_SDC  = 1;
    localparam L_QC   = 2;
    localparam L_DECF = 3;
    localparam L_STM  = 4;
    localparam L_PIT  = 5;
    localparam L_REAC = 6;
    localparam L_CAN  = 7;
    localparam L_ISL  = 8;
    localparam L_DMA  = 9;
    localparam L_FCU  = 10;
    localparam L_TIO  = 11;
    localparam L_IGF  = L_TIO + TIO_CH;
    localparam L_SNS  = L_IGF + IGF_N;
    localparam LANES  = L_SNS + SNS_CH;

    // supervision state codes
    localparam [1:0] ST_NORMAL = `DEAFC_ST_NORMAL;
    localparam [1:0] ST_DEBUG  = `DEAFC_ST_DEBUG;
    localparam [1:0] ST_ROGUE  = `DEAFC_ST_ROGUE;

    // any non-run code of the stop field freezes the converter
    function qc_stops;
        input [`DEAFC_QC_FLD_W-1:0] fld;
        begin
            qc_stops = (fld != `DEAFC_QC_RUN_CODE);
        end
    endfunction

    wire [`DEAFC_PIN_W-1:0] pin_s;
    wire                    comp_s;
    wire                    dbg_req_s;
    wire                    test_s;
    wire                    cmd_s;

    reg  [1:0]       state_r;
    reg  [1:0]       state_nxt;
    reg              cmd_d_r;
    reg              test_d_r;
    reg              lockout_r;
    reg              cmd_accept_r;
    reg              dbg_fault_r;
    reg              test_fault_r;
    reg              dbg_sts_r;
    reg              test_sts_r;
    reg              spp_halt_r;
    reg              interrupt_controller_halt_r;
    reg              dbg_fault_nxt;
    wire             dbg_active;
    wire             cmd_rise;
    wire             test_rise;
    wire [LANES-1:0] frz_en;
    wire [LANES-1:0] halt;

    deafc_sync
    #(
        .W (`DEAFC_PIN_W)
    )
    u_sync
    (
        .clk_i  (CLK_I),
        .srst_i (SRST_I),
        .d_i    ({TAP_CMD_STROBE_I, TEST_PIN_I, DEBUG_REQ_I,
                  TAP_COMPLIANCE_SELECT_I}),
        .q_o    (pin_s)
    );

    assign comp_s    = pin_s[`DEAFC_PIN_COMP];
    assign dbg_req_s = pin_s[`DEAFC_PIN_DBG];
    assign test_s    = pin_s[`DEAFC_PIN_TEST];
    assign cmd_s     = pin_s[`DEAFC_PIN_CMD];

    // debug supervision; a debug request with select low is only seen
    // through a failure, so the rogue state exists to be reported
    always @*
    begin
        state_nxt     = state_r;
        dbg_fault_nxt = 1'b0;
        case (state_r)
            ST_NORMAL:
            begin
                if (dbg_req_s && comp_s)
                    state_nxt = ST_DEBUG;
                else if (dbg_req_s)
                begin
                    state_nxt     = ST_ROGUE;
                    dbg_fault_nxt = 1'b1;
                end
            end
            ST_DEBUG:
            begin
                if (!dbg_req_s || !comp_s)
                    state_nxt = ST_NORMAL;
            end
            ST_ROGUE:
            begin
                if (!dbg_req_s)
                    state_nxt = ST_NORMAL;
            end
            default:
                state_nxt = ST_NORMAL;
        endcase
    end

    always @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            state_r     <= ST_NORMAL;
            dbg_fault_r <= 1'b0;
        end
        else
        begin
            state_r     <= state_nxt;
            dbg_fault_r <= dbg_fault_nxt;
        end
    end

    assign dbg_active = (state_r != ST_NORMAL);

    // lockout is sticky until reset: once the fault unit has seen a
    // rogue entry, no later tap command strobe is accepted
    always @(posedge CLK_I)
    begin
        if (SRST_I)
            lockout_r <= 1'b0;
        else if (FCU_DBG_FAULT_ACK_I)
            lockout_r <= 1'b1;
    end

    assign cmd_rise = cmd_s & ~cmd_d_r;

    always @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            cmd_d_r      <= 1'b0;
            cmd_accept_r <= 1'b0;
        end
        else
        begin
            cmd_d_r      <= cmd_s;
            cmd_accept_r <= cmd_rise & comp_s & ~lockout_r;
        end
    end

    // test mode supervision; reporting is optional by configuration
    assign test_rise = test_s & ~test_d_r;

    always @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            test_d_r     <= 1'b0;
            test_fault_r <= 1'b0;
        end
        else
        begin
            test_d_r     <= test_s;
            test_fault_r <= test_rise & FCU_TEST_SUPERVISE_EN_I;
        end
    end

    // sticky fault status; a new event in the clear cycle wins
    always @(posedge CLK_I)
    begin
        if (SRST_I)
        begin
            dbg_sts_r  <= 1'b0;
            test_sts_r <= 1'b0;
        end
        else
        begin
            if (dbg_fault_r)
                dbg_sts_r <= 1'b1;
            else if (FAULT_STS_CLR_I)
                dbg_sts_r <= 1'b0;
            if (test_fault_r)
                test_sts_r <= 1'b1;
            else if (FAULT_STS_CLR_I)
                test_sts_r <= 1'b0;
        end
    end

    // freeze enables; a clear control keeps the lane running
    assign frz_en[L_WDOG] = WDOG_FREEZE_I;
    assign frz_en[L_SDC]  = SDC_FREEZE_I;
    assign frz_en[L_QC]   = qc_stops(QC_DEBUG_STOP_I);
    assign frz_en[L_DECF] = DECF_FREEZE_REQ_EN_I;
    assign frz_en[L_STM]  = STM_FREEZE_I;
    assign frz_en[L_PIT]  = PIT_FREEZE_I;
    assign frz_en[L_REAC] = REAC_FREEZE_REQ_EN_I;
    assign frz_en[L_CAN]  = CAN_FREEZE_I;
    assign frz_en[L_ISL]  = ISL_FREEZE_I;
    assign frz_en[L_DMA]  = DMA_STALL_EN_I;
    assign frz_en[L_FCU]  = FCU_DEBUG_CTRL_I;
    assign frz_en[L_IGF+IGF_N-1:L_IGF] = IGF_FREEZE_I;
    assign frz_en[L_SNS+SNS_CH-1:L_SNS] = SNS_DEBUG_EN_I;
    // a channel halts only when both global and channel freeze are set
    assign frz_en[L_TIO+TIO_CH-1:L_TIO] =
        {TIO_CH{TIO_FREEZE_I}} & TIO_CH_FREEZE_MASK_I;

    deafc_freeze
    #(
        .W (LANES)
    )
    u_freeze
    (
        .clk_i        (CLK_I),
        .srst_i       (SRST_I),
        .dbg_active_i (dbg_active),
        .freeze_en_i  (frz_en),
        .halt_o       (halt)
    );

    // serial port: a freeze waits for the running transfer to end, and
    // with freeze clear it never halts, so transfers always complete
    always @(posedge CLK_I)
    begin
        if (SRST_I)
            spp_halt_r <= 1'b0;
        else if (!dbg_active || !SPP_FREEZE_I)
            spp_halt_r <= 1'b0;
        else if (!SPP_XFER_BUSY_I)
            spp_halt_r <= 1'b1;
    end

    // the interrupt controller has no freeze control at all
    always @(posedge CLK_I)
    begin
        if (SRST_I)
            interrupt_controller_halt_r <= 1'b0;
        else
            interrupt_controller_halt_r <= 1'b0;
    end

    assign TAP_RESET_O      = ~comp_s;
    assign TAP_CMD_ACCEPT_O = cmd_accept_r;
    assign TAP_LOCKOUT_O    = lockout_r;
    assign DEBUG_ACTIVE_O   = dbg_active;
    assign FCU_DBG_FAULT_O  = dbg_fault_r;
    assign FCU_TEST_FAULT_O = test_fault_r;
    assign DBG_FAULT_STS_O  = dbg_sts_r;
    assign TEST_FAULT_STS_O = test_sts_r;
    assign TEST_MODE_O      = test_d_r;

    assign WDOG_HALT_O   = halt[L_WDOG];
    assign SDC_HALT_O    = halt[L_SDC];
    assign QC_HALT_O     = halt[L_QC];
    assign DECF_HALT_O   = halt[L_DECF];
    assign STM_HALT_O    = halt[L_STM];
    assign PIT_HALT_O    = halt[L_PIT];
    assign REAC_HALT_O   = halt[L_REAC];
    assign CAN_HALT_O    = halt[L_CAN];
    assign ISL_HALT_O    = halt[L_ISL];
    assign DMA_HALT_O    = halt[L_DMA];
    assign FCU_HALT_O    = halt[L_FCU];
    assign TIO_CH_HALT_O = halt[L_TIO+TIO_CH-1:L_TIO];
    assign IGF_HALT_O    = halt[L_IGF+IGF_N-1:L_IGF];
    assign SNS_HALT_O    = halt[L_SNS+SNS_CH-1:L_SNS];
    assign SPP_HALT_O    = spp_halt_r;
    assign INTERRUPT_CONTROLLER_HALT_O   = interrupt_controller_halt_r;
endmodule

// ---- testbench/deafc_board.sv ----
/* debugger and boot strapping model driving the four pins.
   assumes the bench moves its wishes just after a clock edge. */
`timescale 1ns/10ps
module deafc_board
(
    input  wire boot_i,
    input  wire comp_i,
    input  wire dbg_i,
    input  wire test_i,
    input  wire cmd_i,
    output wire comp_o,
    output wire dbg_o,
    output wire test_o,
    output wire cmd_o
);
    // strapping overrides compliance select and test for the whole boot phase
    assign comp_o = boot_i ? 1'b0 : comp_i;
    assign test_o = boot_i ? 1'b0 : test_i;
    assign dbg_o  = dbg_i;
    assign cmd_o  = cmd_i;
endmodule

// ---- testbench/deafc_monitor.sv ----
/* checker: debug entry supervision, tap lockout and freeze lanes.
   assumes bind onto deafc_top, single clock CLK_I, sync reset SRST_I. */
`timescale 1ns/10ps
module deafc_monitor
#(
    parameter TIO_CH = 8
)
(
    input wire              CLK_I,
    input wire              SRST_I,
    input wire              TAP_COMPLIANCE_SELECT_I,
    input wire              FCU_DBG_FAULT_ACK_I,
    input wire              FAULT_STS_CLR_I,
    input wire              WDOG_FREEZE_I,
    input wire [1:0]        QC_DEBUG_STOP_I,
    input wire              TIO_FREEZE_I,
    input wire [TIO_CH-1:0] TIO_CH_FREEZE_MASK_I,
    input wire              SPP_FREEZE_I,
    input wire              TAP_RESET_O,
    input wire              TAP_CMD_ACCEPT_O,
    input wire              TAP_LOCKOUT_O,
    input wire              DEBUG_ACTIVE_O,
    input wire              FCU_DBG_FAULT_O,
    input wire              DBG_FAULT_STS_O,
    input wire              FCU_TEST_FAULT_O,
    input wire              TEST_MODE_O,
    input wire              WDOG_HALT_O,
    input wire              QC_HALT_O,
    input wire [TIO_CH-1:0] TIO_CH_HALT_O,
    input wire              SPP_HALT_O,
    input wire              INTERRUPT_CONTROLLER_HALT_O
);
    // the pin synchroniser refills after reset, so pin history is trusted later
    reg [1:0] cnt_r;
    always @(posedge CLK_I)
    begin
        if (SRST_I)
            cnt_r <= 2'h0;
        else if (cnt_r != 2'h3)
            cnt_r <= cnt_r + 2'h1;
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SRST_I);
    sequence s_rogue;
        $rose(DEBUG_ACTIVE_O) && $past(TAP_RESET_O);
    endsequence
    a_tap_reset_pin: assert property (
        cnt_r == 2'h3 |-> TAP_RESET_O == !$past(TAP_COMPLIANCE_SELECT_I, 2))
        else $error("tap reset does not follow compliance select");
    a_rogue_report: assert property (
        s_rogue |-> FCU_DBG_FAULT_O ##1 DBG_FAULT_STS_O)
        else $error("rogue debug entry not reported");
    a_fault_cause: assert property (
        FCU_DBG_FAULT_O |-> s_rogue)
        else $error("debug fault without rogue entry");
    a_sts_hold: assert property (
        DBG_FAULT_STS_O && !FAULT_STS_CLR_I |=> DBG_FAULT_STS_O)
        else $error("debug fault status lost");
    a_lockout_set: assert property (
        FCU_DBG_FAULT_ACK_I |=> TAP_LOCKOUT_O [*3])
        else $error("lockout not set by fault unit");
    a_lockout_hold: assert property (
        TAP_LOCKOUT_O |=> TAP_LOCKOUT_O)
        else $error("lockout released");
    a_cmd_refused: assert property (
        TAP_LOCKOUT_O && $past(TAP_LOCKOUT_O) |-> !TAP_CMD_ACCEPT_O)
        else $error("command accepted under lockout");
    a_cmd_select: assert property (
        TAP_CMD_ACCEPT_O |-> !$past(TAP_RESET_O) ##1 !TAP_CMD_ACCEPT_O)
        else $error("command accepted with tap in reset");
    a_wdog_lane: assert property (
        WDOG_HALT_O == $past(DEBUG_ACTIVE_O && WDOG_FREEZE_I))
        else $error("watchdog halt wrong");
    a_qc_lane: assert property (
        QC_HALT_O == $past(DEBUG_ACTIVE_O && QC_DEBUG_STOP_I != 2'h0))
        else $error("queued converter halt wrong");
    a_tio_lane: assert property (
        TIO_CH_HALT_O == $past({TIO_CH{DEBUG_ACTIVE_O && TIO_FREEZE_I}} & TIO_CH_FREEZE_MASK_I))
        else $error("timer io halt wrong");
    a_spp_cause: assert property (
        SPP_HALT_O |-> $past(DEBUG_ACTIVE_O && SPP_FREEZE_I))
        else $error("serial port halted without freeze");
    a_interrupt_controller_free: assert property (!INTERRUPT_CONTROLLER_HALT_O)
        else $error("interrupt controller halted");
    a_test_report: assert property (
        FCU_TEST_FAULT_O |-> $rose(TEST_MODE_O))
        else $error("test fault without test entry");
endmodule
bind deafc_top deafc_monitor #(.TIO_CH(TIO_CH)) u_mon (.CLK_I(CLK_I), .SRST_I(SRST_I),
    .TAP_COMPLIANCE_SELECT_I(TAP_COMPLIANCE_SELECT_I), .FAULT_STS_CLR_I(FAULT_STS_CLR_I),
    .FCU_DBG_FAULT_ACK_I(FCU_DBG_FAULT_ACK_I), .WDOG_FREEZE_I(WDOG_FREEZE_I),
    .QC_DEBUG_STOP_I(QC_DEBUG_STOP_I), .TIO_FREEZE_I(TIO_FREEZE_I),
    .TIO_CH_FREEZE_MASK_I(TIO_CH_FREEZE_MASK_I), .SPP_FREEZE_I(SPP_FREEZE_I),
    .TAP_RESET_O(TAP_RESET_O), .TAP_CMD_ACCEPT_O(TAP_CMD_ACCEPT_O),
    .TAP_LOCKOUT_O(TAP_LOCKOUT_O), .DEBUG_ACTIVE_O(DEBUG_ACTIVE_O),
    .FCU_DBG_FAULT_O(FCU_DBG_FAULT_O), .DBG_FAULT_STS_O(DBG_FAULT_STS_O),
    .FCU_TEST_FAULT_O(FCU_TEST_FAULT_O), .TEST_MODE_O(TEST_MODE_O),
    .WDOG_HALT_O(WDOG_HALT_O), .QC_HALT_O(QC_HALT_O), .TIO_CH_HALT_O(TIO_CH_HALT_O),
    .SPP_HALT_O(SPP_HALT_O), .INTERRUPT_CONTROLLER_HALT_O(INTERRUPT_CONTROLLER_HALT_O));

// ---- testbench/test_deafc_top.sv ----
/* self-checking bench for debug entry, lockout, test supervision, freezes.
   assumes deafc_top with default sizes and the board model on its pins. */
`timescale 1ns/10ps
module test_deafc_top;
    reg clk = 0, rst = 1, boot = 1, comp = 1, dbg = 0, tst = 1, cmd = 0;
    reg ack = 0, sup = 1, clr = 0, busy = 0;
    reg [11:0] fz = 0;
    reg [1:0] qc = 0, sns = 0;
    reg [7:0] msk = 0;
    reg [3:0] input_glitch_filter = 0;
    wire cp, dp, tp, sp, trst, acc, lock, dact, dflt, tflt, dsts, tsts, tmode;
    wire qh, spph, intch;
    wire [9:0] hs;
    wire [7:0] th;
    wire [3:0] ih;
    wire [1:0] sh;
    int n_fail = 0, checks_done = 0, n_acc = 0, n_df = 0, n_tf = 0;
    deafc_board brd (.boot_i(boot), .comp_i(comp), .dbg_i(dbg), .test_i(tst), .cmd_i(cmd),
        .comp_o(cp), .dbg_o(dp), .test_o(tp), .cmd_o(sp));
    deafc_top dut (.CLK_I(clk), .SRST_I(rst), .TAP_COMPLIANCE_SELECT_I(cp), .DEBUG_REQ_I(dp),
        .TEST_PIN_I(tp), .TAP_CMD_STROBE_I(sp), .FCU_DBG_FAULT_ACK_I(ack),
        .FCU_TEST_SUPERVISE_EN_I(sup), .FAULT_STS_CLR_I(clr), .WDOG_FREEZE_I(fz[0]),
        .SDC_FREEZE_I(fz[1]), .QC_DEBUG_STOP_I(qc), .DECF_FREEZE_REQ_EN_I(fz[2]),
        .STM_FREEZE_I(fz[3]), .PIT_FREEZE_I(fz[4]), .TIO_FREEZE_I(fz[10]),
        .TIO_CH_FREEZE_MASK_I(msk), .REAC_FREEZE_REQ_EN_I(fz[5]), .IGF_FREEZE_I(input_glitch_filter),
        .CAN_FREEZE_I(fz[6]), .SPP_FREEZE_I(fz[11]), .SPP_XFER_BUSY_I(busy),
        .ISL_FREEZE_I(fz[7]), .SNS_DEBUG_EN_I(sns), .DMA_STALL_EN_I(fz[8]),
        .FCU_DEBUG_CTRL_I(fz[9]), .TAP_RESET_O(trst), .TAP_CMD_ACCEPT_O(acc),
        .TAP_LOCKOUT_O(lock), .DEBUG_ACTIVE_O(dact), .FCU_DBG_FAULT_O(dflt),
        .FCU_TEST_FAULT_O(tflt), .DBG_FAULT_STS_O(dsts), .TEST_FAULT_STS_O(tsts),
        .TEST_MODE_O(tmode), .WDOG_HALT_O(hs[0]), .SDC_HALT_O(hs[1]), .QC_HALT_O(qh),
        .DECF_HALT_O(hs[2]), .STM_HALT_O(hs[3]), .PIT_HALT_O(hs[4]), .TIO_CH_HALT_O(th),
        .REAC_HALT_O(hs[5]), .IGF_HALT_O(ih), .CAN_HALT_O(hs[6]), .SPP_HALT_O(spph),
        .ISL_HALT_O(hs[7]), .INTERRUPT_CONTROLLER_HALT_O(intch), .SNS_HALT_O(sh), .DMA_HALT_O(hs[8]),
        .FCU_HALT_O(hs[9]));
    initial
    begin
        forever #20 clk = ~clk;
    end
    // pulses are counted mid-cycle, away from the edge the tasks act on
    always @(negedge clk)
    begin
        n_acc += acc;
        n_df += dflt;
        n_tf += tflt;
    end
    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // wide enough for the longest packed group of halts compared at once
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task strobe;
        n_acc = 0;
        cmd <= 1;
        cyc(2);
        cmd <= 0;
        cyc(5);
    endtask
    task t_freeze;
        fz <= 0; qc <= 0; msk <= 8'hFF; input_glitch_filter <= 0; sns <= 0; busy <= 1;
        cyc(3);
        chk(hs, 0);
        chk({th, ih, sh, qh, spph, intch}, 0);
        fz <= 12'hFFF; msk <= 8'hA5; input_glitch_filter <= 4'h6; sns <= 2'h2;
        cyc(3);
        chk({hs, ih, sh}, {10'h3FF, 4'h6, 2'h2});
        chk({th, spph, intch}, {8'hA5, 2'b00});
        busy <= 0;
        cyc(3);
        chk(spph, 1);
        for (int q = 1; q < 4; q++)
        begin
            qc <= q[1:0];
            cyc(2);
            chk(qh, 1);
        end
        fz <= 0; qc <= 0;
        cyc(2);
        chk({hs, qh, th, spph}, 0);
    endtask
    task t_legal;
        cyc(5);
        chk(trst, 0);
        n_df = 0;
        dbg <= 1;
        cyc(5);
        chk({dact, dsts}, 2'b10);
        chk(n_df, 0);
        t_freeze;
        strobe;
        chk(n_acc, 1);
        // request and select drop together: a request left standing with
        // select low would be a fresh rogue entry
        comp <= 0;
        dbg <= 0;
        cyc(5);
        chk({trst, dact}, 2'b10);
        chk(n_df, 0);
        cyc(3);
    endtask
    task t_rogue;
        n_df = 0;
        dbg <= 1;
        cyc(6);
        chk({dact, dsts, n_df[1:0]}, 4'b1101);
        strobe;
        chk(n_acc, 0);
        dbg <= 0;
        cyc(4);
        dbg <= 1;
        cyc(6);
        chk(n_df, 2);
        ack <= 1;
        cyc(1);
        ack <= 0;
        comp <= 1;
        cyc(5);
        strobe;
        chk({n_acc[1:0], lock}, 3'b001);
        clr <= 1;
        cyc(1);
        clr <= 0;
        cyc(1);
        chk(dsts, 0);
        dbg <= 0;
    endtask
    task t_test;
        n_tf = 0;
        tst <= 1;
        cyc(6);
        chk({tmode, tsts, n_tf[1:0]}, 4'b1101);
        tst <= 0; clr <= 1;
        cyc(1);
        clr <= 0; sup <= 0;
        cyc(5);
        chk({tmode, tsts}, 0);
        tst <= 1;
        cyc(6);
        chk({tmode, tsts, n_tf[1:0]}, 4'b1001);
    endtask
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        wrap_up;
    end
    initial
    begin
        cyc(5);
        rst <= 0;
        cyc(4);
        chk({trst, tmode, dact}, 3'b100);
        tst <= 0;
        boot <= 0;
        t_legal;
        t_rogue;
        t_test;
        wrap_up;
    end
endmodule
